//--- src/cea_pkg.sv
// Constants, types and register map of the configuration EEPROM engine
package cea_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] CTL_OFF = 8'hBC;
  localparam logic [7:0] STS_OFF = 8'hC0;
  localparam logic [7:0] MSK_OFF = 8'hC4;

  // ==========================================================
  // Field positions in the control dword
  localparam int START_B  = 0;
  localparam int CMD_B    = 1;
  localparam int ERR_B    = 2;
  localparam int ALOK_B   = 3;
  localparam int ALST_B   = 4;
  localparam int ALDIS_B  = 5;
  localparam int RATE_LSB = 6;
  localparam int ADDR_LSB = 9;
  localparam int DATA_LSB = 16;

  // ==========================================================
  // Reset values and encodings
  localparam logic [1:0] RATE_RST  = 2'h1;
  localparam logic       ALDIS_RST = 1'b1;
  localparam logic [1:0] RATE_STD  = 2'h1;
  localparam logic [1:0] RATE_TEST = 2'h3;
  localparam logic [6:0] AUTO_ADDR = 7'h00;

  // ==========================================================
  // Timing: half an EEPROM clock period in pclk cycles
  localparam int CORE_MHZ  = 125;
  localparam int PCLK_MHZ  = 25;
  localparam int RATE_DIV  = 1024;
  localparam int HALF_CYC  = RATE_DIV / 2 * PCLK_MHZ / CORE_MHZ;
  localparam int TEST_HALF = 4;

  // ==========================================================
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NACK = 1;
  localparam int IRQ_AUTO = 2;
  localparam int IRQ_W    = 3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_BITS  = 2'b10,
    ST_STOP  = 2'b11
  } cea_st_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [1:0] rate;
    logic       al_dis;
    logic       cmd;
  } cea_ctl_t;

  typedef struct packed {
    logic scl;
    logic sda_out;
    logic sda_oe;
  } cea_pins_t;

endpackage : cea_pkg

//--- src/cea_top.sv
// Register-driven access engine for a serial configuration EEPROM
//
// Functional notes
// - Writing start bit launches one access
// - Command bit: zero read, one write
// - Missing acknowledge sets the error flag
// - Autoload success flag, cleared by reading
// - Autoload status flag, never cleared by reading
// - Autoload disable bit, resets to one
// - Clock rate field sets EEPROM clock divider
// - Word address comes from bits 15:9
// - Control, address and data share dword BCh
// - Data field written, loaded by reads
`timescale 1ns/1ps
module cea_top
#(
  parameter logic [6:0] DEV_ADDR = 7'h50,
  parameter int         HALF_STD = cea_pkg::HALF_CYC
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // EEPROM pins
  output cea_pkg::cea_pins_t     ee_pins,
  input  wire logic              ee_sda_in,
  // Autoload result and interrupt
  output logic      [15:0]       al_word,
  output logic                   al_valid,
  output logic                   irq
);
  import cea_pkg::*;
  // ==========================================================
  // Declarations
  cea_st_t          st;
  cea_ctl_t         ctl;
  logic [15:0]      data, rx;
  logic [6:0]       lat_addr;
  logic [1:0]       bcnt;
  logic [3:0]       bidx;
  logic [9:0]       div_cnt, div_lim, gap;
  logic [IRQ_W-1:0] sts, msk;
  logic [7:0]       tx_cur;
  logic [31:0]      rd_mux;
  // Sequencer and flag state
  logic             lat_wr, is_auto, nack, err, scl, oe;
  logic             al_ok, al_stat, al_pend;
  // Decoded strobes and conditions
  logic             acc, wr, rd_bc, wr_bc, mapped, busy, tick;
  logic             launch_sw, launch_auto, fin, samp_nack;
  logic             master_tx, drive_lo;

  // ==========================================================
  // APB decode; zero wait states, error on unmapped offsets
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign wr_bc   = wr && (paddr == CTL_OFF);
  assign rd_bc   = acc && !pwrite && (paddr == CTL_OFF);
  assign mapped  = (paddr == CTL_OFF) || (paddr == STS_OFF)
                || (paddr == MSK_OFF);
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // Read view of the registers
  assign busy = (st != ST_IDLE);
  always_comb begin
    case (paddr)
      CTL_OFF: rd_mux = {data, ctl.addr, 1'b0, ctl.rate,
                         ctl.al_dis, al_stat, al_ok, err,
                         ctl.cmd, busy};
      STS_OFF: rd_mux = {29'h0000000, sts};
      MSK_OFF: rd_mux = {29'h0000000, msk};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data captured in the setup cycle, so it is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  // ==========================================================
  // Launch: software wins over a pending autoload
  assign launch_sw   = wr_bc && pwdata[START_B] && !busy;
  assign launch_auto = !busy && al_pend && !ctl.al_dis
                    && !launch_sw;

  // ==========================================================
  // Control fields; frozen while a cycle runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl.addr   <= 7'h00;
      ctl.rate   <= RATE_RST;
      ctl.al_dis <= ALDIS_RST;
      ctl.cmd    <= 1'b0;
    end else if (wr_bc && !busy) begin
      ctl.addr   <= pwdata[ADDR_LSB +: 7];
      ctl.rate   <= pwdata[RATE_LSB +: 2];
      ctl.al_dis <= pwdata[ALDIS_B];
      ctl.cmd    <= pwdata[CMD_B];
    end
  end

  // Data field: software write, or the word of a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data <= 16'h0000;
    end else if (fin && !lat_wr && !nack && !is_auto) begin
      data <= rx;
    end else if (wr_bc && !busy) begin
      data <= pwdata[DATA_LSB +: 16];
    end
  end

  // ==========================================================
  // Divider; reserved codes run standard, a launch's rate is used at once
  assign div_lim = ((launch_sw ? pwdata[RATE_LSB +: 2] : ctl.rate)
                    == RATE_TEST)
                 ? 10'(TEST_HALF - 1)
                 : 10'(HALF_STD - 1);
  assign tick = busy && (div_cnt == 10'h000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 10'h000;
    end else if (!busy || div_cnt == 10'h000) begin
      div_cnt <= div_lim;
    end else begin
      div_cnt <= div_cnt - 10'h001;
    end
  end
  // Cycles since the last divider tick, watched by the rate check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 10'h000;
    end else begin
      gap <= (!busy || tick) ? 10'h000 : gap + 10'h001;
    end
  end

  // ==========================================================
  // Byte on the wire: device select, word address, data
  assign master_tx = lat_wr || (bcnt < 2'h2);
  always_comb begin
    case (bcnt)
      2'h0:    tx_cur = {DEV_ADDR, !lat_wr};
      2'h1:    tx_cur = {lat_addr, 1'b0};
      2'h2:    tx_cur = data[15:8];
      default: tx_cur = data[7:0];
    endcase
  end
  // Ack slot: host acks the first read byte, not the last
  assign drive_lo = (bidx < 4'h8)
                  ? (master_tx && !tx_cur[3'd7 - bidx[2:0]])
                  : (!master_tx && bcnt == 2'h2);
  assign samp_nack = (st == ST_BITS) && tick && !scl
                  && (bidx == 4'h8) && master_tx
                  && ee_sda_in;
  assign fin = (st == ST_STOP) && tick && (bidx >= 4'h2);

  // ==========================================================
  // Sequencer: start, bytes with ack slots, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st       <= ST_IDLE;
      bcnt     <= 2'h0;
      bidx     <= 4'h0;
      scl      <= 1'b1;
      oe       <= 1'b0;
      lat_wr   <= 1'b0;
      lat_addr <= 7'h00;
      is_auto  <= 1'b0;
      nack     <= 1'b0;
      rx       <= 16'h0000;
    end else begin
      case (st)
        ST_IDLE: begin
          if (launch_sw || launch_auto) begin
            st       <= ST_START;
            lat_wr   <= launch_sw && pwdata[CMD_B];
            lat_addr <= launch_sw ? pwdata[ADDR_LSB +: 7]
                                  : AUTO_ADDR;
            is_auto  <= !launch_sw;
            bcnt     <= 2'h0;
            bidx     <= 4'h0;
            nack     <= 1'b0;
            scl      <= 1'b1;
            oe       <= 1'b0;
          end
        end
        ST_START: begin
          if (tick) begin
            oe <= 1'b1;
            st <= ST_BITS;
          end
        end
        ST_BITS: begin
          if (tick && scl) begin
            scl <= 1'b0;
            oe  <= drive_lo;
          end else if (tick) begin
            scl <= 1'b1;
            if (bidx == 4'h8) begin
              bidx <= 4'h0;
              if (samp_nack) begin
                nack <= 1'b1;
                st   <= ST_STOP;
              end else if (bcnt == 2'h3) begin
                st <= ST_STOP;
              end else begin
                bcnt <= bcnt + 2'h1;
              end
            end else begin
              if (!master_tx) begin
                rx <= {rx[14:0], ee_sda_in};
              end
              bidx <= bidx + 4'h1;
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            case (bidx)
              4'h0: begin
                scl  <= 1'b0;
                oe   <= 1'b1;
                bidx <= 4'h1;
              end
              4'h1: begin
                scl  <= 1'b1;
                bidx <= 4'h2;
              end
              default: begin
                oe <= 1'b0;
                st <= ST_IDLE;
              end
            endcase
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  assign ee_pins = '{scl: scl, sda_out: 1'b0, sda_oe: oe};

  // ==========================================================
  // Error flag: held until the next software launch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= 1'b0;
    end else if (samp_nack) begin
      err <= 1'b1;
    end else if (launch_sw) begin
      err <= 1'b0;
    end
  end

  // ==========================================================
  // Autoload flags and result; a set beats a read-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      al_ok    <= 1'b0;
      al_stat  <= 1'b0;
      al_pend  <= 1'b1;
      al_word  <= 16'h0000;
      al_valid <= 1'b0;
    end else begin
      al_valid <= fin && is_auto && !nack;
      if (fin && is_auto) begin
        al_pend <= 1'b0;
      end
      if (fin && is_auto && !nack) begin
        al_ok   <= 1'b1;
        al_stat <= 1'b1;
        al_word <= rx;
      end else if (rd_bc) begin
        al_ok <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupts: sticky, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts <= 3'h0;
      msk <= 3'h0;
    end else begin
      sts <= (sts & ~((wr && paddr == STS_OFF)
                      ? pwdata[IRQ_W-1:0] : 3'h0))
           | {fin && is_auto && !nack, samp_nack, fin};
      if (wr && paddr == MSK_OFF) begin
        msk <= pwdata[IRQ_W-1:0];
      end
    end
  end
  assign irq = |(sts & msk);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_start; launch_sw |=> st == ST_START; endproperty
  a_start: assert property (p_start)
    else $error("start write did not launch");
  property p_cmd; launch_sw |=> lat_wr == $past(pwdata[1]);
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command bit not taken");
  property p_err; samp_nack |=> err && sts[1]; endproperty
  a_err: assert property (p_err)
    else $error("nack not flagged");
  property p_rdclr; rd_bc && !fin |=> !al_ok; endproperty
  a_rdclr: assert property (p_rdclr)
    else $error("success flag not cleared by read");
  property p_stat; al_stat |=> al_stat; endproperty
  a_stat: assert property (p_stat)
    else $error("autoload status fell");
  property p_dis; ctl.al_dis && !busy |=> !(busy && is_auto); endproperty
  a_dis: assert property (p_dis)
    else $error("autoload ran while disabled");
  property p_rate;
    tick && ctl.rate != RATE_TEST |-> gap == 10'(HALF_STD - 1);
  endproperty
  a_rate: assert property (p_rate)
    else $error("EEPROM clock at wrong rate");
  property p_addr;
    launch_sw |=> lat_addr == $past(pwdata[15:9]);
  endproperty
  a_addr: assert property (p_addr)
    else $error("word address not taken");
  property p_map; acc && paddr == CTL_OFF |-> !pslverr;
  endproperty
  a_map: assert property (p_map)
    else $error("control dword refused");
  property p_data;
    fin && !lat_wr && !nack && !is_auto |=> data == $past(rx);
  endproperty
  a_data: assert property (p_data)
    else $error("read word not loaded");
  property p_fin; fin |=> !busy && (paddr != CTL_OFF || !rd_mux[0]);
  endproperty
  a_fin: assert property (p_fin)
    else $error("start bit still set after cycle");

  c_read:  cover property (fin && !lat_wr && !nack && !is_auto);
  c_write: cover property (fin && lat_wr && !nack);
  c_nack:  cover property (samp_nack);
  c_auto:  cover property (al_valid);

endmodule : cea_top

//--- verif/cea_eeprom_model.sv
// Behavioural serial EEPROM that answers the access engine
`timescale 1ns/1ps
// ==========================================================
module cea_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  // Bus lines
  input  wire logic scl,
  input  wire logic sda,
  // Test control: refuse every acknowledge
  input  wire logic nack_mode,
  // Open-drain pull on the data line
  output logic      pull_low
);
  logic [15:0] mem [0:127];
  logic [7:0]  sh;
  logic [6:0]  wa;
  logic        rd;
  logic        hit;
  int          k;
  int          nb;
  int          ns;

  // Known contents so reads of untouched words can be predicted
  initial begin
    pull_low = 1'b0;
    hit = 1'b0;
    k = 0;
    foreach (mem[i]) mem[i] = 16'h5AC3;
  end

  // Start or stop: data moves while the clock is high
  always @(sda) if (scl === 1'b1) begin
    k = 0;
    hit = 1'b0;
    pull_low = 1'b0;
  end

  // Host bits are taken on the rising clock
  always @(posedge scl) begin
    k = k + 1;
    if ((k - 1) % 9 < 8) sh = {sh[6:0], sda};
    if ((k - 1) % 9 == 7) begin
      case ((k - 1) / 9)
        0: begin
          rd = sh[0];
          hit = (sh[7:1] == DEV_ADDR);
        end
        1: wa = sh[7:1];
        2: if (!rd) mem[wa][15:8] = sh;
        3: if (!rd) mem[wa][7:0] = sh;
        default: ;
      endcase
    end
  end

  // Acknowledge or read data changes only while the clock is low
  always @(negedge scl) begin
    nb = k / 9;
    ns = k % 9;
    if (ns == 8)
      pull_low = hit && !nack_mode && (nb < 2 || !rd);
    else if (rd && hit && (nb == 2 || nb == 3))
      pull_low = !mem[wa][15 - (nb - 2) * 8 - ns];
    else
      pull_low = 1'b0;
  end
endmodule : cea_eeprom_model

//--- verif/tb_cea_top.sv
// Register-level bench for the configuration EEPROM engine
`timescale 1ns/1ps
// ==========================================================
module tb_cea_top;
  import cea_pkg::*;
  localparam int LIMIT = 20000;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  cea_pins_t   ee_pins;
  logic        sda_line;
  logic        pull_low;
  logic        nack_mode;
  logic [15:0] al_word;
  logic        al_valid;
  logic        irq;
  logic [31:0] q;
  logic        serr;
  int          errors;
  int          comparisons;
  int          cyc;
  int          t0;
  int          d_std;
  int          al_cnt;

  // Open-drain data line with a pull-up
  assign sda_line = !(ee_pins.sda_oe || pull_low);

  cea_top #(.DEV_ADDR(7'h50), .HALF_STD(6)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ee_pins(ee_pins),
    .ee_sda_in(sda_line), .al_word(al_word), .al_valid(al_valid),
    .irq(irq)
  );

  cea_eeprom_model #(.DEV_ADDR(7'h50)) ee (
    .scl(ee_pins.scl), .sda(sda_line), .nack_mode(nack_mode),
    .pull_low(pull_low)
  );

  // ==========================================================
  // Clock, hang guard and autoload pulse counter
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      tally_and_finish();
    end
  end

  // Sampled away from the edge that updates it
  always @(negedge pclk) if (al_valid === 1'b1) al_cnt++;

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; waits on pready rather than assuming zero wait
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Poll the start bit as a busy flag
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, CTL_OFF, 32'h0);
      n++;
    end while (q[START_B] !== 1'b0 && n < 2000);
  endtask : wait_idle

  // Control word with start set and autoload kept disabled
  function automatic logic [31:0] ctl(input logic [15:0] d,
      input logic [6:0] a, input logic [1:0] r, input logic c);
    return {d, a, 1'b0, r, 1'b1, 3'b000, c, 1'b1};
  endfunction : ctl

  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Test sequence
  initial begin
    errors = 0;
    comparisons = 0;
    cyc = 0;
    al_cnt = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nack_mode = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then an unmapped place
    apb(1'b0, CTL_OFF, 32'h0);
    chk("ctl_reset", 32'h00000060, q);
    apb(1'b0, 8'hD0, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("slverr", 32'h1, 32'(serr));
    // Write cycle at the top word address
    apb(1'b1, CTL_OFF, ctl(16'hC35A, 7'h7F, RATE_STD, 1'b1));
    wait_idle();
    chk("wr_ctl", {16'hC35A, 7'h7F, 1'b0, RATE_STD, 6'h22}, q);
    chk("ee_word", 32'(16'hC35A), 32'(ee.mem[7'h7F]));
    // Done status, masked then unmasked, then cleared
    apb(1'b0, STS_OFF, 32'h0);
    chk("sts_done", 32'h1, q);
    @(negedge pclk);
    chk("irq_masked", 32'h0, 32'(irq));
    apb(1'b1, MSK_OFF, 32'h1);
    @(negedge pclk);
    chk("irq_on", 32'h1, 32'(irq));
    apb(1'b1, STS_OFF, 32'h7);
    @(negedge pclk);
    chk("irq_off", 32'h0, 32'(irq));
    // Read back at standard rate, then word 0 in test mode
    apb(1'b1, CTL_OFF, ctl(16'h0000, 7'h7F, RATE_STD, 1'b0));
    t0 = cyc;
    wait_idle();
    d_std = cyc - t0;
    chk("rd_ctl", {16'hC35A, 7'h7F, 1'b0, RATE_STD, 6'h20}, q);
    apb(1'b1, CTL_OFF, ctl(16'h0000, 7'h00, RATE_TEST, 1'b0));
    t0 = cyc;
    wait_idle();
    chk("rd_test", {16'h5AC3, 7'h00, 1'b0, RATE_TEST, 6'h20}, q);
    chk("test_faster", 32'h1, 32'((cyc - t0) < d_std));
    // Reserved rate code runs like the standard rate
    apb(1'b1, CTL_OFF, ctl(16'h0000, 7'h7F, 2'h2, 1'b0));
    wait_idle();
    chk("rd_rsvd", {16'hC35A, 7'h7F, 1'b0, 2'h2, 6'h20}, q);
    // Refused acknowledge: error set, data field not loaded
    nack_mode = 1'b1;
    apb(1'b1, CTL_OFF, ctl(16'h0000, 7'h05, RATE_TEST, 1'b0));
    wait_idle();
    chk("nack_ctl", {16'h0000, 7'h05, 1'b0, RATE_TEST, 6'h24}, q);
    apb(1'b0, STS_OFF, 32'h0);
    chk("nack_sts", 32'h2, q & 32'h2);
    nack_mode = 1'b0;
    apb(1'b1, STS_OFF, 32'h7);
    // Autoload held off while disabled, runs once enabled
    chk("al_held", 32'h0, 32'(al_cnt));
    apb(1'b1, CTL_OFF, 32'h00000040);
    for (int n = 0; n < 3000 && al_valid !== 1'b1; n++) @(negedge pclk);
    chk("al_word", 32'(16'h5AC3), 32'(al_word));
    repeat (4) @(posedge pclk);
    chk("al_once", 32'h1, 32'(al_cnt));
    apb(1'b0, CTL_OFF, 32'h0);
    chk("al_flags", 32'h18, q & 32'h18);
    apb(1'b0, CTL_OFF, 32'h0);
    chk("al_rdclr", 32'h10, q & 32'h18);
    apb(1'b0, STS_OFF, 32'h0);
    chk("al_sts", 32'h4, q & 32'h4);
    // Second reset in mid-run restores every field
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTL_OFF, 32'h0);
    chk("ctl_reset2", 32'h00000060, q);
    tally_and_finish();
  end
endmodule : tb_cea_top
